// ### plc_gateway_mailbox_cfg.svh
// Offsets, field positions, codes and timing figures of the gateway mailbox
`ifndef PLC_GATEWAY_MAILBOX_CFG_SVH
`define PLC_GATEWAY_MAILBOX_CFG_SVH

// ====
// Configuration area word indices
`define IDX_RECV_TYPE    5'h00
`define IDX_RECV_BLOCK   5'h01
`define IDX_RECV_START   5'h02
`define IDX_RECV_CAP     5'h03
`define IDX_SEND_TYPE    5'h05
`define IDX_SEND_BLOCK   5'h06
`define IDX_SEND_START   5'h07
`define IDX_SEND_CAP     5'h08
`define IDX_SEND_COUNT   5'h0A
`define IDX_SEND_RESULT  5'h0B
`define IDX_SEND_FLAGS   5'h0C
`define IDX_RECV_COUNT   5'h0D
`define IDX_RECV_RESULT  5'h0E
`define IDX_RECV_FLAGS   5'h0F
`define IDX_POLL_PERIOD  5'h10

// ====
// Handshake word bit positions
`define BIT_ACT          0
`define BIT_ERR          1
`define BIT_DONE         2

// ====
// Area type character codes
`define AREA_DB          8'h44
`define AREA_DX          8'h58
`define AREA_FLAG        8'h4D
`define AREA_INPUT       8'h45
`define AREA_OUTPUT      8'h41

// ====
// Result codes
`define RES_OK           16'h0000
`define RES_BAD_TYPE     16'h0001
`define RES_OVER_CAP     16'h0002
`define RES_OVER_UNIT    16'h0003
`define RES_NET_FAIL     16'h0004
`define RES_RX_OVERFLOW  16'h0005
`define RES_RX_LINK      16'h0006

// ====
// Link constants and timing
`define ISO_TCP_PORT     16'h0066
`define TPDU_BYTES       16'h0200
`define POLL_UNIT_NS     1000000
`define MCLK_NS          25
`define RESET_WORD       16'h0000
`define RESET_BYTE       8'h00

`endif

// ### plc_gateway_mailbox_pkg.sv
// Types shared by the gateway mailbox modules
package plc_gateway_mailbox_pkg;

  // Send job sequencer
  typedef enum logic [2:0] {
    SEND_IDLE  = 3'b000,
    SEND_FETCH = 3'b001,
    SEND_WAIT  = 3'b010,
    SEND_LOAD  = 3'b011,
    SEND_PUSH  = 3'b100,
    SEND_CODE  = 3'b101,
    SEND_FLAG  = 3'b110
  } send_state_t;

  // Receive job sequencer
  typedef enum logic [1:0] {
    RECV_IDLE = 2'b00,
    RECV_OPEN = 2'b01,
    RECV_CODE = 2'b10,
    RECV_FLAG = 2'b11
  } recv_state_t;

  typedef logic [15:0] word_t;
  typedef logic [7:0]  byte_t;

endpackage

// ### poll_if.sv
// Carrier between the mailbox engine and its poll timer
`timescale 1ns/10ps
`default_nettype none

interface poll_if;
  logic [15:0] period;
  logic        poll;

  modport engine (output period, input poll);
  modport timer  (input period, output poll);
endinterface

`default_nettype wire

// ### poll_timer.sv
// Millisecond poll timer that paces rereading of the configuration area
`timescale 1ns/10ps
`default_nettype none
`include "plc_gateway_mailbox_cfg.svh"

module poll_timer #(
  parameter int MS_CYCLES = `POLL_UNIT_NS / `MCLK_NS
) (
  // Clock and reset
  input  wire logic  mclk,
  input  wire logic  rst_n,
  // Period in, poll pulse out
  poll_if.timer      pif
);

  logic [31:0] pre_q, pre_d;
  logic [15:0] ms_q,  ms_d;
  logic        poll_q, poll_d;
  logic        tick;

  // Prescaler gives a one-cycle enable per millisecond
  always_comb begin
    tick   = (pre_q == 32'(MS_CYCLES - 1));
    pre_d  = tick ? 32'h00000000 : pre_q + 32'h00000001;
    ms_d   = ms_q;
    poll_d = 1'b0;
    if (pif.period == `RESET_WORD) begin
      ms_d   = `RESET_WORD;
      poll_d = 1'b1;                       // [R16]
    end else if (tick) begin
      if (ms_q + 16'h0001 >= pif.period) begin
        ms_d   = `RESET_WORD;
        poll_d = 1'b1;                     // [R16]
      end else begin
        ms_d = ms_q + 16'h0001;
      end
    end
  end

  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pre_q  <= 32'h00000000;
      ms_q   <= `RESET_WORD;
      poll_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      ms_q   <= ms_d;
      poll_q <= poll_d;
    end
  end

  assign pif.poll = poll_q;

endmodule

`default_nettype wire

// ### plc_gateway_mailbox.sv
// Send and receive mailbox engine of the network gateway
`timescale 1ns/10ps
`default_nettype none
`include "plc_gateway_mailbox_cfg.svh"

// Behaviour
// [R01] Receive type byte selects memory class: D, X, M, E or A.
// [R02] Receive block number used only for D and X types.
// [R03] Receive start is a data word for D/X, else a byte address.
// [R04] Receive capacity counts bytes, also inside word-organised blocks.
// [R05] Send type byte uses the same five class codes.
// [R06] Send start is word for D/X, else byte; block only for D/X.
// [R07] Send capacity counts bytes, also inside data blocks.
// [R08] Controller writes the send byte count; gateway only reads it.
// [R09] Send request flag starts a send job; both sides may write it.
// [R10] Good send sets complete flag and leaves result code zero.
// [R11] Failed send sets fault flag and an error result code.
// [R12] Incoming bytes are accepted only while the receive armed flag is set.
// [R13] After reception set new-data flag and write received byte count.
// [R14] Receive error sets receive fault flag and an error result code.
// [R15] Receive result code is zero after error-free reception.
// [R16] Configuration is rechecked once per poll period; zero means always.
// [R17] ISO-on-TCP connections use TCP port 102.
// [R18] Each connection carries a 16-character transport access point.
// [R19] No package exceeds the 512-byte transport unit.
// [R20] Result code and count are written a cycle before any flag.
module plc_gateway_mailbox
  import plc_gateway_mailbox_pkg::*;
#(
  parameter int     MS_CYCLES = `POLL_UNIT_NS / `MCLK_NS,
  parameter [127:0] TSAP      = 128'h47415445574159204D41494C424F5831
) (
  // Clock and reset
  input  wire logic                           mclk,
  input  wire logic                           rst_n,
  // Register port
  input  wire logic [4:0]                     reg_addr,
  input  wire plc_gateway_mailbox_pkg::word_t reg_wdata,
  input  wire logic                           reg_wr,
  input  wire logic                           reg_rd,
  output logic      [15:0]                    reg_rdata,
  // Controller memory port
  output logic                                mem_req,
  output logic                                mem_we,
  output logic      [7:0]                     mem_area,
  output logic      [15:0]                    mem_block,
  output logic      [16:0]                    mem_addr,
  output logic      [7:0]                     mem_wdata,
  input  wire plc_gateway_mailbox_pkg::byte_t mem_rdata,
  // Transmit stream
  output logic                                tx_valid,
  output logic      [7:0]                     tx_data,
  output logic                                tx_last,
  input  wire logic                           tx_ready,
  input  wire logic                           tx_fail,
  // Receive stream
  input  wire logic                           rx_valid,
  input  wire plc_gateway_mailbox_pkg::byte_t rx_data,
  input  wire logic                           rx_last,
  input  wire logic                           rx_error,
  output logic                                rx_ready,
  // Connection identity
  output logic      [15:0]                    iso_port,
  output logic      [127:0]                   link_tsap
);

  // ====
  // Declarations
  poll_if pif ();

  byte_t       rtype_q, rtype_d, stype_q, stype_d;
  word_t       rblock_q, rblock_d, rstart_q, rstart_d, rcap_q, rcap_d;
  word_t       sblock_q, sblock_d, sstart_q, sstart_d, scap_q, scap_d;
  word_t       scount_q, scount_d, sres_q, sres_d;
  word_t       rcount_q, rcount_d, rres_q, rres_d, period_q, period_d;
  logic [2:0]  sflags_q, sflags_d, rflags_q, rflags_d;
  word_t       rdata_q, rdata_d;

  send_state_t ss_q, ss_d;
  recv_state_t rs_q, rs_d;
  logic [9:0]  sidx_q, sidx_d, ridx_q, ridx_d;
  word_t       scode_q, scode_d, rcode_q, rcode_d;
  logic        txv_q, txv_d, txl_q, txl_d;
  byte_t       txd_q, txd_d;
  logic        rxr_q, rxr_d;
  logic        mreq_q, mreq_d, mwe_q, mwe_d;
  byte_t       marea_q, marea_d, mwd_q, mwd_d;
  word_t       mblk_q, mblk_d;
  logic [16:0] maddr_q, maddr_d;
  logic        rx_take;

  // ====
  // Helpers
  function automatic logic is_block(input byte_t t);
    is_block = (t == `AREA_DB) || (t == `AREA_DX);
  endfunction

  function automatic logic type_ok(input byte_t t);
    type_ok = is_block(t) || (t == `AREA_FLAG) ||
              (t == `AREA_INPUT) || (t == `AREA_OUTPUT);
  endfunction

  // Word start doubles to a byte address inside data blocks
  function automatic logic [16:0] byte_addr(input byte_t t,
                                            input word_t s,
                                            input logic [9:0] off);
    if (is_block(t))
      byte_addr = {s, 1'b0} + {7'h00, off};
    else
      byte_addr = {1'b0, s} + {7'h00, off};
  endfunction

  // Block number is meaningless outside data blocks, so it goes out zero
  function automatic word_t block_of(input byte_t t, input word_t b);
    block_of = is_block(t) ? b : `RESET_WORD;
  endfunction

  // ====
  // Poll timer
  assign pif.period = period_q;

  poll_timer #(
    .MS_CYCLES (MS_CYCLES)
  ) poll_timer_i (
    .mclk  (mclk),
    .rst_n (rst_n),
    .pif   (pif)
  );

  // ====
  // Send sequencer; the receive side owns the memory port when it writes
  always_comb begin
    ss_d    = ss_q;
    sidx_d  = sidx_q;
    scode_d = scode_q;
    txv_d   = txv_q;
    txl_d   = txl_q;
    txd_d   = txd_q;
    unique case (ss_q)
      SEND_IDLE: begin
        if (pif.poll && sflags_q[`BIT_ACT]) begin         // [R09] [R16]
          sidx_d  = 10'h000;
          scode_d = `RES_OK;
          ss_d    = SEND_FETCH;
          if (!type_ok(stype_q)) begin                    // [R05]
            scode_d = `RES_BAD_TYPE;
            ss_d    = SEND_CODE;
          end else if (scount_q > scap_q) begin           // [R07] [R08]
            scode_d = `RES_OVER_CAP;
            ss_d    = SEND_CODE;
          end else if (scount_q > `TPDU_BYTES) begin      // [R19]
            scode_d = `RES_OVER_UNIT;
            ss_d    = SEND_CODE;
          end else if (scount_q == `RESET_WORD) begin
            ss_d    = SEND_CODE;
          end
        end
      end
      SEND_FETCH: begin
        if (!rx_take)
          ss_d = SEND_WAIT;
      end
      SEND_WAIT: ss_d = SEND_LOAD;
      SEND_LOAD: begin
        txd_d = mem_rdata;
        txv_d = 1'b1;
        txl_d = ({6'h00, sidx_q} == scount_q - 16'h0001);
        ss_d  = SEND_PUSH;
      end
      SEND_PUSH: begin
        if (tx_ready) begin
          txv_d  = 1'b0;
          txl_d  = 1'b0;
          sidx_d = sidx_q + 10'h001;
          ss_d   = txl_q ? SEND_CODE : SEND_FETCH;
        end
      end
      SEND_CODE: ss_d = SEND_FLAG;                        // [R20]
      SEND_FLAG: ss_d = SEND_IDLE;
      default:   ss_d = SEND_IDLE;
    endcase
    // Link failure aborts the job at any stage of transfer
    if (tx_fail && (ss_q inside {SEND_FETCH, SEND_WAIT,
                                 SEND_LOAD, SEND_PUSH})) begin
      scode_d = `RES_NET_FAIL;                            // [R11]
      txv_d   = 1'b0;
      txl_d   = 1'b0;
      ss_d    = SEND_CODE;
    end
  end

  // ====
  // Receive sequencer
  assign rx_take = rx_valid && rxr_q && rflags_q[`BIT_ACT];  // [R12]

  always_comb begin
    rs_d    = rs_q;
    ridx_d  = ridx_q;
    rcode_d = rcode_q;
    unique case (rs_q)
      RECV_IDLE: begin
        if (pif.poll && rflags_q[`BIT_ACT] && type_ok(rtype_q)) begin // [R01]
          ridx_d  = 10'h000;
          rcode_d = `RES_OK;                              // [R15]
          rs_d    = RECV_OPEN;
        end
      end
      RECV_OPEN: begin
        if (!rflags_q[`BIT_ACT]) begin
          rs_d = RECV_IDLE;
        end else if (rx_take) begin
          if (rx_error) begin
            rcode_d = `RES_RX_LINK;                       // [R14]
            rs_d    = RECV_CODE;
          end else if (({6'h00, ridx_q} >= rcap_q) ||     // [R04]
                       ({6'h00, ridx_q} >= `TPDU_BYTES)) begin // [R19]
            rcode_d = `RES_RX_OVERFLOW;                   // [R14]
            rs_d    = RECV_CODE;
          end else begin
            ridx_d = ridx_q + 10'h001;
            if (rx_last)
              rs_d = RECV_CODE;
          end
        end
      end
      RECV_CODE: rs_d = RECV_FLAG;                        // [R20]
      RECV_FLAG: rs_d = RECV_IDLE;
    endcase
    // Ready is registered; it drops as soon as the mailbox closes
    rxr_d = (rs_d == RECV_OPEN) && rflags_d[`BIT_ACT];
  end

  // ====
  // Memory port: one byte per request, receive writes win the port
  always_comb begin
    mreq_d  = 1'b0;
    mwe_d   = 1'b0;
    marea_d = marea_q;
    mblk_d  = mblk_q;
    maddr_d = maddr_q;
    mwd_d   = mwd_q;
    if (rx_take && (rs_q == RECV_OPEN) && (rs_d != RECV_CODE || rx_last) &&
        !rx_error && ({6'h00, ridx_q} < rcap_q) &&
        ({6'h00, ridx_q} < `TPDU_BYTES)) begin
      mreq_d  = 1'b1;
      mwe_d   = 1'b1;
      marea_d = rtype_q;                                  // [R01]
      mblk_d  = block_of(rtype_q, rblock_q);              // [R02]
      maddr_d = byte_addr(rtype_q, rstart_q, ridx_q);     // [R03]
      mwd_d   = rx_data;
    end else if ((ss_q == SEND_FETCH) && !tx_fail && !rx_take) begin
      mreq_d  = 1'b1;
      marea_d = stype_q;                                  // [R05]
      mblk_d  = block_of(stype_q, sblock_q);              // [R06]
      maddr_d = byte_addr(stype_q, sstart_q, sidx_q);     // [R06]
    end
  end

  // ====
  // Register file; hardware sets win over controller clears
  always_comb begin
    rtype_d  = rtype_q;
    rblock_d = rblock_q;
    rstart_d = rstart_q;
    rcap_d   = rcap_q;
    stype_d  = stype_q;
    sblock_d = sblock_q;
    sstart_d = sstart_q;
    scap_d   = scap_q;
    scount_d = scount_q;
    period_d = period_q;
    sres_d   = sres_q;
    rcount_d = rcount_q;
    rres_d   = rres_q;
    sflags_d = sflags_q;
    rflags_d = rflags_q;
    // Gateway clears the request and arm bits when a job finishes
    if (ss_q == SEND_FLAG)
      sflags_d[`BIT_ACT] = 1'b0;                          // [R09]
    if (rs_q == RECV_FLAG)
      rflags_d[`BIT_ACT] = 1'b0;
    if (reg_wr) begin
      unique case (reg_addr)
        `IDX_RECV_TYPE:   rtype_d  = reg_wdata[7:0];
        `IDX_RECV_BLOCK:  rblock_d = reg_wdata;
        `IDX_RECV_START:  rstart_d = reg_wdata;
        `IDX_RECV_CAP:    rcap_d   = reg_wdata;
        `IDX_SEND_TYPE:   stype_d  = reg_wdata[7:0];
        `IDX_SEND_BLOCK:  sblock_d = reg_wdata;
        `IDX_SEND_START:  sstart_d = reg_wdata;
        `IDX_SEND_CAP:    scap_d   = reg_wdata;
        `IDX_SEND_COUNT:  scount_d = reg_wdata;           // [R08]
        `IDX_SEND_FLAGS:  sflags_d = reg_wdata[2:0];
        `IDX_RECV_FLAGS:  rflags_d = reg_wdata[2:0];
        `IDX_POLL_PERIOD: period_d = reg_wdata;
        default: ;
      endcase
    end
    // Status words land one cycle before their flag
    if (ss_q == SEND_CODE)
      sres_d = scode_q;                                   // [R10] [R11] [R20]
    if (rs_q == RECV_CODE) begin
      rres_d   = rcode_q;                                 // [R15] [R20]
      rcount_d = {6'h00, ridx_q};                         // [R13]
    end
    if (ss_q == SEND_FLAG) begin
      if (scode_q == `RES_OK)
        sflags_d[`BIT_DONE] = 1'b1;                       // [R10]
      else
        sflags_d[`BIT_ERR] = 1'b1;                        // [R11]
    end
    if (rs_q == RECV_FLAG) begin
      if (rcode_q == `RES_OK)
        rflags_d[`BIT_DONE] = 1'b1;                       // [R13]
      else
        rflags_d[`BIT_ERR] = 1'b1;                        // [R14]
    end
  end

  // Read data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = `RESET_WORD;
    if (reg_rd) begin
      unique case (reg_addr)
        `IDX_RECV_TYPE:   rdata_d = {8'h00, rtype_q};
        `IDX_RECV_BLOCK:  rdata_d = rblock_q;
        `IDX_RECV_START:  rdata_d = rstart_q;
        `IDX_RECV_CAP:    rdata_d = rcap_q;
        `IDX_SEND_TYPE:   rdata_d = {8'h00, stype_q};
        `IDX_SEND_BLOCK:  rdata_d = sblock_q;
        `IDX_SEND_START:  rdata_d = sstart_q;
        `IDX_SEND_CAP:    rdata_d = scap_q;
        `IDX_SEND_COUNT:  rdata_d = scount_q;
        `IDX_SEND_RESULT: rdata_d = sres_q;
        `IDX_SEND_FLAGS:  rdata_d = {13'h0000, sflags_q};
        `IDX_RECV_COUNT:  rdata_d = rcount_q;
        `IDX_RECV_RESULT: rdata_d = rres_q;
        `IDX_RECV_FLAGS:  rdata_d = {13'h0000, rflags_q};
        `IDX_POLL_PERIOD: rdata_d = period_q;
        default:          rdata_d = `RESET_WORD;
      endcase
    end
  end

  // ====
  // Registers
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rtype_q  <= `RESET_BYTE;
      stype_q  <= `RESET_BYTE;
      rblock_q <= `RESET_WORD;
      rstart_q <= `RESET_WORD;
      rcap_q   <= `RESET_WORD;
      sblock_q <= `RESET_WORD;
      sstart_q <= `RESET_WORD;
      scap_q   <= `RESET_WORD;
      scount_q <= `RESET_WORD;
      sres_q   <= `RESET_WORD;
      rcount_q <= `RESET_WORD;
      rres_q   <= `RESET_WORD;
      period_q <= `RESET_WORD;
      sflags_q <= 3'h0;
      rflags_q <= 3'h0;
      rdata_q  <= `RESET_WORD;
      ss_q     <= SEND_IDLE;
      rs_q     <= RECV_IDLE;
      sidx_q   <= 10'h000;
      ridx_q   <= 10'h000;
      scode_q  <= `RES_OK;
      rcode_q  <= `RES_OK;
      txv_q    <= 1'b0;
      txl_q    <= 1'b0;
      txd_q    <= `RESET_BYTE;
      rxr_q    <= 1'b0;
      mreq_q   <= 1'b0;
      mwe_q    <= 1'b0;
      marea_q  <= `RESET_BYTE;
      mblk_q   <= `RESET_WORD;
      maddr_q  <= 17'h00000;
      mwd_q    <= `RESET_BYTE;
    end else begin
      rtype_q  <= rtype_d;
      stype_q  <= stype_d;
      rblock_q <= rblock_d;
      rstart_q <= rstart_d;
      rcap_q   <= rcap_d;
      sblock_q <= sblock_d;
      sstart_q <= sstart_d;
      scap_q   <= scap_d;
      scount_q <= scount_d;
      sres_q   <= sres_d;
      rcount_q <= rcount_d;
      rres_q   <= rres_d;
      period_q <= period_d;
      sflags_q <= sflags_d;
      rflags_q <= rflags_d;
      rdata_q  <= rdata_d;
      ss_q     <= ss_d;
      rs_q     <= rs_d;
      sidx_q   <= sidx_d;
      ridx_q   <= ridx_d;
      scode_q  <= scode_d;
      rcode_q  <= rcode_d;
      txv_q    <= txv_d;
      txl_q    <= txl_d;
      txd_q    <= txd_d;
      rxr_q    <= rxr_d;
      mreq_q   <= mreq_d;
      mwe_q    <= mwe_d;
      marea_q  <= marea_d;
      mblk_q   <= mblk_d;
      maddr_q  <= maddr_d;
      mwd_q    <= mwd_d;
    end
  end

  // Connection identity, fixed flops so outputs are registered
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      iso_port  <= `ISO_TCP_PORT;                         // [R17]
      link_tsap <= TSAP;                                  // [R18]
    end else begin
      iso_port  <= `ISO_TCP_PORT;
      link_tsap <= TSAP;
    end
  end

  // ====
  // Output wiring straight from flops
  assign reg_rdata = rdata_q;
  assign mem_req   = mreq_q;
  assign mem_we    = mwe_q;
  assign mem_area  = marea_q;
  assign mem_block = mblk_q;
  assign mem_addr  = maddr_q;
  assign mem_wdata = mwd_q;
  assign tx_valid  = txv_q;
  assign tx_data   = txd_q;
  assign tx_last   = txl_q;
  assign rx_ready  = rxr_q;

endmodule

`default_nettype wire

// ### plc_gateway_mailbox_chk.sv
// Port assertions for the gateway mailbox engine
`timescale 1ns/10ps
`default_nettype none

module plc_gateway_mailbox_chk #(
  parameter [127:0] TSAP = 128'h0
) (
  // Clock and reset
  input wire logic         mclk,
  input wire logic         rst_n,
  // Memory port
  input wire logic         mem_req,
  input wire logic         mem_we,
  input wire logic [7:0]   mem_area,
  input wire logic [15:0]  mem_block,
  // Streams
  input wire logic         tx_valid,
  input wire logic [7:0]   tx_data,
  input wire logic         tx_last,
  input wire logic         tx_ready,
  input wire logic         tx_fail,
  input wire logic         rx_valid,
  input wire logic         rx_last,
  input wire logic         rx_error,
  input wire logic         rx_ready,
  // Identity
  input wire logic [15:0]  iso_port,
  input wire logic [127:0] link_tsap
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // ====
  // Identity and memory port
  a_port_fixed: assert property (iso_port == 16'h0066)
    else $error("iso port wrong");
  a_tsap_fixed: assert property (link_tsap == TSAP)
    else $error("tsap wrong");
  a_area_code: assert property (mem_req |-> mem_area inside
    {8'h44, 8'h58, 8'h4D, 8'h45, 8'h41}) else $error("bad area");
  a_block_unused: assert property (mem_req && mem_area != 8'h44
    && mem_area != 8'h58 |-> mem_block == 16'h0000)
    else $error("block used");
  // ====
  // Stream timing
  a_rx_armed: assert property (mem_req && mem_we
    |-> $past(rx_valid && rx_ready && !rx_error)) else $error("stray write");
  a_rx_close: assert property (rx_valid && rx_ready && rx_last
    |=> !rx_ready) else $error("ready after last");
  a_tx_hold: assert property (tx_valid && !tx_ready && !tx_fail
    |=> tx_valid && $stable(tx_data) && $stable(tx_last))
    else $error("tx dropped");
  a_fetch_push: assert property (mem_req && !mem_we && !tx_fail
    ##1 !tx_fail |=> tx_valid) else $error("fetch lost");
endmodule

bind plc_gateway_mailbox plc_gateway_mailbox_chk #(.TSAP(TSAP)) chk_i (
  .mclk(mclk), .rst_n(rst_n), .mem_req(mem_req), .mem_we(mem_we),
  .mem_area(mem_area), .mem_block(mem_block), .tx_valid(tx_valid),
  .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
  .tx_fail(tx_fail), .rx_valid(rx_valid), .rx_last(rx_last),
  .rx_error(rx_error), .rx_ready(rx_ready), .iso_port(iso_port),
  .link_tsap(link_tsap));

`default_nettype wire

// ### ctl_mem_model.sv
// Controller memory model behind the gateway byte port
`timescale 1ns/10ps
`default_nettype none

module ctl_mem_model (
  // Clock
  input  wire logic        mclk,
  // Byte port
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [16:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:255];
  // Fixed fill to predict sent bytes
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
  end
  // Data valid one cycle only; bus wanders after, to expose late sampling
  always @(posedge mclk) begin
    if (mem_req && !mem_we) begin
      mem_rdata <= mem[mem_addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata;
    end
    if (mem_req && mem_we) begin
      mem[mem_addr[7:0]] <= mem_wdata;
    end
  end
endmodule

`default_nettype wire

// ### plc_gateway_mailbox_tb_top.sv
// Self-checking bench for the gateway mailbox engine
`timescale 1ns/10ps
`default_nettype none

module plc_gateway_mailbox_tb_top;
  import plc_gateway_mailbox_pkg::*;
  // Arbitrary access point text
  localparam [127:0] TSAP = 128'h30313233343536373839414243444546;
  logic mclk, rst_n, reg_wr, reg_rd, tx_ready, tx_fail, slow, hold;
  logic rx_valid, rx_last, rx_error, mem_req, mem_we, tx_valid;
  logic tx_last, rx_ready;
  logic [4:0] reg_addr;
  word_t reg_wdata;
  byte_t rx_data, mem_rdata;
  logic [15:0] reg_rdata, mem_block, iso_port;
  logic [7:0] mem_area, mem_wdata, tx_data;
  logic [16:0] mem_addr;
  logic [127:0] link_tsap;
  int n_errors, checks;
  byte_t txq[$];

  plc_gateway_mailbox #(.MS_CYCLES(4), .TSAP(TSAP)) plc_gateway_mailbox_i (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mem_req(mem_req), .mem_we(mem_we),
    .mem_area(mem_area), .mem_block(mem_block), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .tx_fail(tx_fail), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_last(rx_last), .rx_error(rx_error), .rx_ready(rx_ready),
    .iso_port(iso_port), .link_tsap(link_tsap));
  ctl_mem_model ctl_mem_model_i (.mclk(mclk), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));

  // ====
  // Clock, sink stalls and byte capture
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    tx_ready <= !hold && (!slow || !tx_ready);
    if (tx_valid && tx_ready) txq.push_back(tx_data);
  end

  // ====
  // Bus cycles and compares
  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input word_t d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output word_t v);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // Polls a flag word until complete or fault shows
  task automatic fin(input logic [4:0] a, output word_t v);
    for (int n = 0; n < 300; n++) begin
      rd(a, v);
      if (v[2:1] != 2'b00) break;
    end
  endtask
  task automatic snd(input byte_t ty, input word_t cnt, cap, res, fl);
    word_t v;
    txq = {};
    wr(5'h05, {8'h00, ty});
    wr(5'h06, 16'h0009);
    wr(5'h07, 16'h0005);
    wr(5'h08, cap);
    wr(5'h0A, cnt);
    wr(5'h0C, 16'h0001);
    fin(5'h0C, v);
    chk(v, fl);
    rd(5'h0B, v);
    chk(v, res);
  endtask
  // Byte held until the edge that sees ready; released line wanders
  task automatic rxb(input byte_t d, input logic l, e);
    logic ok;
    int n;
    n = 0;
    @(posedge mclk);
    rx_valid <= 1'b1;
    rx_data <= d;
    rx_last <= l;
    rx_error <= e;
    do begin
      #1 ok = (rx_ready === 1'b1);
      @(posedge mclk);
      n++;
    end while (!ok && n < 40);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask
  task automatic rcv(input word_t cap, n, d, input logic e,
                     input word_t res, fl);
    word_t v;
    wr(5'h00, 16'h0058);
    wr(5'h01, 16'h0002);
    wr(5'h02, 16'h0004);
    wr(5'h03, cap);
    wr(5'h0F, 16'h0001);
    for (int i = 0; i < n; i++) rxb(d[7:0] + 8'(i), i == n - 1, e);
    fin(5'h0F, v);
    chk(v, fl);
    rd(5'h0E, v);
    chk(v, res);
  endtask

  // ====
  // Scenarios
  task automatic t_reset;
    word_t v;
    chk(iso_port, 16'h0066);
    chk(link_tsap[15:0], TSAP[15:0]);
    chk({15'h0, rx_ready}, 16'h0000);
    wr(5'h0B, 16'hFFFF);
    rd(5'h0B, v);
    chk(v, 16'h0000);
    wr(5'h08, 16'h1234);
    rd(5'h08, v);
    chk(v, 16'h1234);
    rd(5'h11, v);
    chk(v, 16'h0000);
  endtask
  task automatic t_send_ok;
    byte_t ty[5] = '{8'h44, 8'h58, 8'h4D, 8'h45, 8'h41};
    int b;
    foreach (ty[k]) begin
      slow = k[0];
      snd(ty[k], 16'h0003, 16'h0003, 16'h0000, 16'h0004);
      b = (k < 2) ? 10 : 5;
      chk(16'(txq.size()), 16'h0003);
      foreach (txq[i]) chk({8'h00, txq[i]}, 16'(8'(b + i) ^ 8'hA5));
    end
    slow = 1'b0;
    snd(8'h44, 16'h0000, 16'h0003, 16'h0000, 16'h0004);
  endtask
  task automatic t_send_err;
    snd(8'h5A, 16'h0002, 16'h0003, 16'h0001, 16'h0002);
    snd(8'h44, 16'h0004, 16'h0003, 16'h0002, 16'h0002);
    snd(8'h44, 16'h0201, 16'h0400, 16'h0003, 16'h0002);
    hold = 1'b1;
    fork
      snd(8'h44, 16'h0002, 16'h0003, 16'h0004, 16'h0002);
      begin
        wait (tx_valid === 1'b1);
        @(posedge mclk);
        tx_fail <= 1'b1;
        @(posedge mclk);
        tx_fail <= 1'b0;
      end
    join
    hold = 1'b0;
  endtask
  task automatic t_recv;
    word_t v;
    rcv(16'h0003, 16'h0003, 16'h0030, 1'b0, 16'h0000, 16'h0004);
    rd(5'h0D, v);
    chk(v, 16'h0003);
    for (int i = 0; i < 3; i++)
      chk({8'h00, ctl_mem_model_i.mem[8+i]}, 16'(8'h30 + i));
    chk({15'h0, rx_ready}, 16'h0000);
    rcv(16'h0001, 16'h0002, 16'h0060, 1'b0, 16'h0005, 16'h0002);
    chk({8'h00, ctl_mem_model_i.mem[9]}, 16'h0031);
    rcv(16'h0003, 16'h0001, 16'h0070, 1'b1, 16'h0006, 16'h0002);
  endtask

  task automatic summarize;
    if (n_errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ====
  // Main sequence and watchdog
  initial begin
    {rst_n, reg_wr, reg_rd, tx_fail, rx_valid, rx_last, rx_error} = '0;
    {tx_ready, slow, hold, reg_addr, reg_wdata, rx_data} = '0;
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset();
    t_send_ok();
    t_send_err();
    t_recv();
    summarize();
  end
  initial begin
    #2000000;
    n_errors++;
    summarize();
  end
endmodule

`default_nettype wire
